// file: verification/emt_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module emt_ctrl_chk #(
  parameter int ADDR_W = 18
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              mem_busy,
  input wire logic              mem_done,
  input wire logic              mem_oe_n,
  input wire logic              mem_we_n,
  input wire logic              prom_sclk,
  input wire logic              prom_ce_n,
  input wire logic              prom_write_enable_n,
  input wire logic              prom_write_bit_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic serial_write_mode;
  assign serial_write_mode = psel && penable && pready && pwrite && !pslverr &&
                  paddr[ADDR_W-1:2] == emt_pkg::IDX_SER_CTL;
  ////////////////////////////////////////////////////////////////////////////////
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("setup cycle not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // Pins are a registered copy, so they trail the register by one clock.
  ser_pins_a: assert property (serial_write_mode |=> ##1 (prom_ce_n == $past(pwdata[2], 2) &&
    prom_write_enable_n == $past(pwdata[1], 2))) else $error("serial pins ignore write");
  strobe_excl_a: assert property (!(!mem_oe_n && !mem_we_n))
    else $error("both strobes low");
  done_pulse_a: assert property (mem_done |=> !mem_done)
    else $error("done longer than one cycle");
  done_idle_a: assert property (mem_done |-> !mem_busy)
    else $error("busy still high with done");
  done_after_busy_a: assert property ($rose(mem_done) |-> $past(mem_busy))
    else $error("done without a running cycle");
  reset_pins_a: assert property ($rose(presetn) |-> prom_ce_n && prom_write_enable_n &&
    !prom_write_bit_oe && !prom_sclk) else $error("serial pins wrong after reset");
endmodule
`default_nettype wire

// file: verification/emt_prom_model.sv
`timescale 1ns/1ps
`default_nettype none
// Serial PROM: shifts its stored bits out, lowest first, on each clock rise while selected.
module emt_prom_model #(
  parameter logic [7:0] PATTERN = 8'h5a
) (
  input  wire logic pclk,
  input  wire logic sclk,
  input  wire logic ce_n,
  output logic      read_bit
);
  logic [7:0] shift_ff = PATTERN;
  logic       junk_ff = 1'h0;
  always @(posedge sclk) begin
    if (!ce_n) begin
      shift_ff <= {shift_ff[0], shift_ff[7:1]};
    end
  end
  // A deselected part floats; a toggling level keeps stale data from passing a read.
  always @(posedge pclk) begin
    junk_ff <= ~junk_ff;
  end
  assign read_bit = ce_n ? junk_ff : shift_ff[0];
endmodule
`default_nettype wire

// file: verification/tb_ext_mem_strobe_timing_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ext_mem_strobe_timing_ctrl;
  localparam int AW = 18;
  logic          pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [AW-1:0] paddr = 18'h0;
  logic [31:0]   pwdata = 32'h0, prdata, rdv;
  logic          pready, pslverr, errv, lowv, stb_n;
  logic          mem_req = 1'h0, mem_write = 1'h0, mem_expansion = 1'h0;
  logic          mem_busy, mem_done, mem_oe_n, mem_we_n, prom_sclk, prom_ce_n;
  logic          prom_write_enable_n, prom_write_bit, prom_write_bit_oe, prom_read_bit;
  int            n_errors = 0, total_checks = 0, cyc = 0;
  real           tf, tr, s0, s1;
  emt_ctrl #(.ADDR_W(AW)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_write(mem_write), .mem_expansion(mem_expansion),
    .mem_busy(mem_busy), .mem_done(mem_done), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .prom_sclk(prom_sclk), .prom_ce_n(prom_ce_n), .prom_write_enable_n(prom_write_enable_n),
    .prom_write_bit(prom_write_bit), .prom_write_bit_oe(prom_write_bit_oe),
    .prom_read_bit(prom_read_bit));
  emt_prom_model u_prom (.pclk(pclk), .sclk(prom_sclk), .ce_n(prom_ce_n), .read_bit(prom_read_bit));
  ////////////////////////////////////////////////////////////////////////////////
  assign stb_n = mem_oe_n & mem_we_n;
  always #12.5 pclk = ~pclk;
  // Edge times give the half-clock strobe figures exactly, which a cycle count cannot.
  always @(negedge stb_n) begin
    tf = $realtime;
    lowv = mem_we_n;
  end
  always @(posedge stb_n) tr = $realtime;
  always @(posedge prom_sclk) begin
    s0 = s1;
    s1 = $realtime;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'h1;
    // The answer is taken at the rising edge that sees pready high, before the flops move.
    do @(posedge pclk); while (pready !== 1'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] m, input logic [7:0] e,
                    input logic er);
    apb(1'h0, idx, 8'h0);
    chk(errv === er && (rdv & {24'h0, m}) === {24'h0, e}, "read value");
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic er);
    apb(1'h1, idx, d);
    chk(errv === er, "write response");
    repeat (2) @(negedge pclk);
  endtask
  task automatic mem(input logic w, input logic x, input int s, input int p, input int h);
    real t1;
    @(posedge pclk);
    mem_req <= 1'h1;
    mem_write <= w;
    mem_expansion <= x;
    @(posedge pclk);
    t1 = $realtime;
    mem_req <= 1'h0;
    @(posedge mem_done);
    @(negedge pclk);
    chk(lowv === ~w, "strobe choice");
    chk(tf - t1 == (s + 0.5) * 25.0, "strobe setup");
    chk(tr - tf == (p + 0.5) * 25.0, "strobe width");
    chk($realtime - 12.5 - t1 == (s + p + 1 + h) * 25.0, "cycle length");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(emt_pkg::IDX_TIM_LO, 8'hff, 8'h00, 1'h1);
    wr(emt_pkg::IDX_DMAP_CTL, 8'h01, 1'h0);
    rd(emt_pkg::IDX_TIM_LO, 8'hff, 8'hff, 1'h0);
    rd(emt_pkg::IDX_TIM_HI, 8'hff, 8'h7f, 1'h0);
    rd(emt_pkg::IDX_SER_CTL, 8'h6f, 8'h47, 1'h0);
    rd(16'hfe3f, 8'hff, 8'h00, 1'h1);
    mem(1'h0, 1'h0, 7, 7, 0);
    mem(1'h1, 1'h0, 7, 7, 7);
    $display("test reset_defaults done");
    wr(emt_pkg::IDX_TIM_LO, 8'h5a, 1'h0);
    wr(emt_pkg::IDX_TIM_HI, 8'h01, 1'h0);
    mem(1'h1, 1'h0, 2, 3, 5);
    mem(1'h0, 1'h0, 0, 0, 0);
    wr(emt_pkg::IDX_TIM_HI, 8'h94, 1'h0);
    rd(emt_pkg::IDX_TIM_HI, 8'hff, 8'h94, 1'h0);
    mem(1'h0, 1'h1, 3, 1, 0);
    mem(1'h1, 1'h1, 3, 3, 1);
    mem(1'h0, 1'h0, 2, 1, 0);
    $display("test strobe_timing done");
    wr(emt_pkg::IDX_SER_CTL, 8'h43, 1'h0);
    chk(prom_ce_n === 1'h0 && prom_write_enable_n === 1'h1 && prom_sclk === 1'h0, "select");
    rd(emt_pkg::IDX_SER_CTL, 8'h80, 8'h00, 1'h0);
    wr(emt_pkg::IDX_SER_CTL, 8'h4b, 1'h0);
    chk(prom_sclk === 1'h1, "prom clock");
    rd(emt_pkg::IDX_SER_CTL, 8'h80, 8'h80, 1'h0);
    wr(emt_pkg::IDX_SER_CTL, 8'hc1, 1'h0);
    chk(prom_write_enable_n === 1'h0 && prom_sclk === 1'h0, "prom write enable");
    rd(emt_pkg::IDX_SER_CTL, 8'h7f, 8'h41, 1'h0);
    wr(emt_pkg::IDX_MODE, 8'h02, 1'h0);
    wr(emt_pkg::IDX_SER_CTL, 8'h11, 1'h0);
    chk(prom_write_bit_oe === 1'h1 && prom_write_bit === 1'h1 && mem_oe_n === 1'h1, "drive");
    wr(emt_pkg::IDX_SER_CTL, 8'h20, 1'h0);
    chk(prom_write_bit_oe === 1'h0 && prom_write_bit === 1'h0 && mem_oe_n === 1'h0, "release");
    wr(emt_pkg::IDX_SER_CTL, 8'h45, 1'h0);
    wr(emt_pkg::IDX_MODE, 8'h01, 1'h0);
    rd(emt_pkg::IDX_MODE, 8'h03, 8'h01, 1'h0);
    repeat (3) @(posedge prom_sclk);
    @(negedge pclk);
    chk(s1 - s0 == 1600.0, "slow serial clock");
    wr(emt_pkg::IDX_SER_CTL, 8'h05, 1'h0);
    repeat (3) @(posedge prom_sclk);
    @(negedge pclk);
    chk(s1 - s0 == 100.0, "fast serial clock");
    wr(emt_pkg::IDX_MODE, 8'h00, 1'h0);
    wr(emt_pkg::IDX_SER_CTL, 8'h15, 1'h0);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    wr(emt_pkg::IDX_DMAP_CTL, 8'h01, 1'h0);
    rd(emt_pkg::IDX_SER_CTL, 8'h7f, 8'h57, 1'h0);
    rd(emt_pkg::IDX_MODE, 8'h03, 8'h00, 1'h0);
    rd(emt_pkg::IDX_TIM_LO, 8'hff, 8'hff, 1'h0);
    $display("test serial_control done");
    close_out();
  end
endmodule
bind emt_ctrl emt_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_busy(mem_busy), .mem_done(mem_done), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
  .prom_sclk(prom_sclk), .prom_ce_n(prom_ce_n), .prom_write_enable_n(prom_write_enable_n),
  .prom_write_bit_oe(prom_write_bit_oe));
`default_nettype wire

// file: verilog/emt_ctrl.sv
// Functional notes
// - Write setup lasts write setup field plus half a clock.
// - Write strobe lasts write pulse field plus half a clock.
// - Write hold adds write hold field whole clocks after the strobe.
// - Hold field low bits sit at low byte 7:6, top bit at high byte 0.
// - Read setup lasts read setup field plus half a clock.
// - Read strobe lasts read pulse field plus half a clock.
// - Reset loads every three-bit timing field with all ones.
// - Expansion setup bit adds one setup clock to expansion cycles; reset clears.
// - Serial bit 0 drives memory output-enable pin in serial mode; reset sets.
// - Serial bit 1 drives PROM write enable; reset sets it inactive.
// - Serial bit 2 drives PROM chip enable; reset sets it, deselected.
// - Serial bit 4 is PROM write data; reset leaves it alone.
// - Serial bit 5 low enables the data buffer in write mode; reset clears.
// - Serial bit 6 picks read clock divide 4 or 64; reset sets it.
// - Serial bit 7 reads the PROM data input; writes ignore it.
// - Strobes open on a falling edge and close on a rising edge.
// - Mode register holds serial read and write mode bits; reset clears both.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module emt_ctrl #(
  parameter int ADDR_W = 18
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              mem_req,
  input  wire logic              mem_write,
  input  wire logic              mem_expansion,
  output logic                   mem_busy,
  output logic                   mem_done,
  output logic                   mem_oe_n,
  output logic                   mem_we_n,
  output logic                   prom_sclk,
  output logic                   prom_ce_n,
  output logic                   prom_write_enable_n,
  output logic                   prom_write_bit,
  output logic                   prom_write_bit_oe,
  input  wire logic              prom_read_bit
);

  typedef struct packed {
    logic [7:0]  tim_lo;
    logic [7:0]  tim_hi;
    logic [6:0]  ser_ctl;
    logic [1:0]  mode;
    logic        hidden;
    logic [5:0]  div_cnt;
    logic        sclk;
    logic        ready;
    logic        err;
    logic [31:0] rdata;
    logic        oe_pin;
    logic        ce_n;
    logic        wr_en_n;
    logic        wbit_oe;
  } emt_ctrl_st_t;

  localparam emt_ctrl_st_t ST_RESET = '{
    tim_lo:  {emt_pkg::TIM_RESET[1:0], emt_pkg::TIM_RESET, emt_pkg::TIM_RESET},
    tim_hi:  {1'b0, emt_pkg::TIM_RESET, emt_pkg::TIM_RESET, emt_pkg::TIM_RESET[2]},
    ser_ctl: emt_pkg::SER_RESET[6:0],
    mode:    2'h0,
    hidden:  1'b0,
    div_cnt: 6'h00,
    sclk:    1'b0,
    ready:   1'b0,
    err:     1'b0,
    rdata:   32'h0000_0000,
    oe_pin:  emt_pkg::SER_RESET[emt_pkg::SC_RESET_OE],
    ce_n:    emt_pkg::SER_RESET[emt_pkg::SC_CE_N],
    wr_en_n: emt_pkg::SER_RESET[emt_pkg::SC_WR_EN_N],
    wbit_oe: 1'b0
  };

  emt_ctrl_st_t         st_ff;
  emt_ctrl_st_t         nxt_st;
  logic                 wbit_ff;
  logic                 nxt_wbit;
  emt_pkg::emt_timing_t timing;
  logic [15:0]          idx;
  logic                 setup_ph;
  logic                 wr_take;
  logic                 serial_mode;
  logic                 seq_oe_n;
  logic                 seq_we_n;
  logic                 seq_busy;
  logic                 seq_done;
  logic [5:0]           half_lim;
  logic [7:0]           ser_view;

  ////////////////////////////////////////////////////////////////////////////
  // Timing fields as the strobe sequencer sees them.
  always_comb begin
    timing.wr_setup  = st_ff.tim_lo[emt_pkg::LO_WSU_POS +: 3];
    timing.wr_pulse  = st_ff.tim_lo[emt_pkg::LO_WPW_POS +: 3];
    timing.wr_hold   = {st_ff.tim_hi[emt_pkg::HI_WHT2_POS],
                        st_ff.tim_lo[emt_pkg::LO_WHT_POS +: 2]};
    timing.rd_setup  = st_ff.tim_hi[emt_pkg::HI_RSU_POS +: 3];
    timing.rd_pulse  = st_ff.tim_hi[emt_pkg::HI_RPW_POS +: 3];
    timing.exp_setup = st_ff.tim_hi[emt_pkg::HI_EXPANSION_EXTRA_SETUP_POS];
  end

  assign serial_mode = |st_ff.mode;

  // Parallel cycles are not started while the pins belong to the serial PROM.
  emt_strobe_seq u_seq (
    .pclk          (pclk),
    .presetn       (presetn),
    .cfg           (timing),
    .req           (mem_req & ~serial_mode),
    .req_write     (mem_write),
    .req_expansion (mem_expansion),
    .busy          (seq_busy),
    .done          (seq_done),
    .oe_n          (seq_oe_n),
    .we_n          (seq_we_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. Registers answer with no wait state; the answer is prepared
  // during the setup cycle so that pready and prdata leave flip-flops.
  assign idx      = paddr[17:2];
  assign setup_ph = psel & ~penable;
  assign wr_take  = psel & penable & pwrite & st_ff.ready & ~st_ff.err;

  assign ser_view = {prom_read_bit, st_ff.ser_ctl[6:5], wbit_ff,
                     st_ff.ser_ctl[3:0]};

  always_comb begin
    nxt_st   = st_ff;
    nxt_wbit = wbit_ff;
    nxt_st.ready = setup_ph;
    nxt_st.err   = 1'b0;
    nxt_st.rdata = 32'h0000_0000;

    if (setup_ph) begin
      unique case (idx)
        emt_pkg::IDX_MODE:     nxt_st.rdata = {30'h0, st_ff.mode};
        emt_pkg::IDX_TIM_LO:   nxt_st.rdata = {24'h0, st_ff.tim_lo};
        emt_pkg::IDX_TIM_HI:   nxt_st.rdata = {24'h0, st_ff.tim_hi};
        emt_pkg::IDX_SER_CTL:  nxt_st.rdata = {24'h0, ser_view};
        emt_pkg::IDX_DMAP_CTL: nxt_st.rdata = {31'h0, st_ff.hidden};
        default:               nxt_st.err   = 1'b1;
      endcase
      // The control set stays hidden until software opens it.
      if (!st_ff.hidden && idx != emt_pkg::IDX_DMAP_CTL) begin
        nxt_st.err   = 1'b1;
        nxt_st.rdata = 32'h0000_0000;
      end
    end

    if (wr_take) begin
      unique case (idx)
        emt_pkg::IDX_MODE: begin
          nxt_st.mode[emt_pkg::MODE_SERIAL_READ_MODE] = pwdata[emt_pkg::MODE_SERIAL_READ_MODE];
          nxt_st.mode[emt_pkg::MODE_SERIAL_WRITE_MODE] = pwdata[emt_pkg::MODE_SERIAL_WRITE_MODE];
        end
        emt_pkg::IDX_TIM_LO: nxt_st.tim_lo = pwdata[7:0];
        emt_pkg::IDX_TIM_HI: nxt_st.tim_hi = pwdata[7:0];
        emt_pkg::IDX_SER_CTL: begin
          nxt_st.ser_ctl = pwdata[6:0] & emt_pkg::SER_WMASK[6:0];
          nxt_wbit       = pwdata[emt_pkg::SC_WBIT];
        end
        emt_pkg::IDX_DMAP_CTL: nxt_st.hidden = pwdata[emt_pkg::DMAP_HIDDEN];
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Serial clock: in read mode a free divider, otherwise the software bit.
    half_lim = st_ff.ser_ctl[emt_pkg::SC_DIV_SEL] ? emt_pkg::HALF_SLOW
                                                  : emt_pkg::HALF_FAST;
    if (st_ff.mode[emt_pkg::MODE_SERIAL_READ_MODE]) begin
      if (st_ff.div_cnt >= half_lim) begin
        nxt_st.div_cnt = 6'h00;
        nxt_st.sclk    = ~st_ff.sclk;
      end else begin
        nxt_st.div_cnt = st_ff.div_cnt + 6'h01;
      end
    end else begin
      nxt_st.div_cnt = 6'h00;
      nxt_st.sclk    = st_ff.ser_ctl[emt_pkg::SC_CLK];
    end

    // PROM pins other than the write data bit follow the control bits one clock after the write.
    nxt_st.oe_pin  = st_ff.ser_ctl[emt_pkg::SC_RESET_OE];
    nxt_st.ce_n    = st_ff.ser_ctl[emt_pkg::SC_CE_N];
    nxt_st.wr_en_n = st_ff.ser_ctl[emt_pkg::SC_WR_EN_N];
    nxt_st.wbit_oe = st_ff.mode[emt_pkg::MODE_SERIAL_WRITE_MODE] &
                     ~st_ff.ser_ctl[emt_pkg::SC_BUF_EN_N];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The write data bit keeps its value through reset, so it has no reset
  // term; it reads unknown until software first writes it.
  always_ff @(posedge pclk) begin
    wbit_ff <= nxt_wbit;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata              = st_ff.rdata;
  assign pready              = st_ff.ready;
  assign pslverr             = st_ff.err;
  assign mem_busy            = seq_busy;
  assign mem_done            = seq_done;
  // The strobes carry half-clock edges and so are gated from two flops.
  assign mem_oe_n            = serial_mode ? st_ff.oe_pin : seq_oe_n;
  assign mem_we_n            = serial_mode | seq_we_n;
  assign prom_sclk           = st_ff.sclk;
  assign prom_ce_n           = st_ff.ce_n;
  assign prom_write_enable_n = st_ff.wr_en_n;
  assign prom_write_bit      = wbit_ff;
  assign prom_write_bit_oe   = st_ff.wbit_oe;

endmodule
`default_nettype wire

// file: verilog/emt_pkg.sv
`default_nettype none
package emt_pkg;

  // Register indices; the byte address on APB is four times the index.
  localparam logic [15:0] IDX_MODE     = 16'hfe30;
  localparam logic [15:0] IDX_TIM_LO   = 16'hfe31;
  localparam logic [15:0] IDX_TIM_HI   = 16'hfe32;
  localparam logic [15:0] IDX_SER_CTL  = 16'hfe33;
  localparam logic [15:0] IDX_DMAP_CTL = 16'hfe40;

  // Low timing byte fields.
  localparam int LO_WSU_POS = 0;
  localparam int LO_WPW_POS = 3;
  localparam int LO_WHT_POS = 6;
  // High timing byte fields.
  localparam int HI_WHT2_POS = 0;
  localparam int HI_RSU_POS  = 1;
  localparam int HI_RPW_POS  = 4;
  localparam int HI_EXPANSION_EXTRA_SETUP_POS = 7;

  // Serial control fields.
  localparam int SC_RESET_OE = 0;
  localparam int SC_WR_EN_N  = 1;
  localparam int SC_CE_N     = 2;
  localparam int SC_CLK      = 3;
  localparam int SC_WBIT     = 4;
  localparam int SC_BUF_EN_N = 5;
  localparam int SC_DIV_SEL  = 6;
  localparam int SC_RBIT     = 7;

  // Mode register and data mapper control fields.
  localparam int MODE_SERIAL_READ_MODE = 0;
  localparam int MODE_SERIAL_WRITE_MODE = 1;
  localparam int DMAP_HIDDEN = 0;

  localparam logic [2:0] TIM_RESET  = 3'h7;
  localparam logic [7:0] SER_RESET  = 8'h47;
  localparam logic [7:0] SER_WMASK  = 8'h7f;

  localparam int SER_DIV_FAST = 4;
  localparam int SER_DIV_SLOW = 64;
  localparam logic [5:0] HALF_FAST = 6'(SER_DIV_FAST / 2 - 1);
  localparam logic [5:0] HALF_SLOW = 6'(SER_DIV_SLOW / 2 - 1);

  typedef struct packed {
    logic       exp_setup;
    logic [2:0] rd_pulse;
    logic [2:0] rd_setup;
    logic [2:0] wr_hold;
    logic [2:0] wr_pulse;
    logic [2:0] wr_setup;
  } emt_timing_t;

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_SETUP,
    SQ_PULSE,
    SQ_HOLD
  } emt_seq_state_t;

endpackage
`default_nettype wire

// file: verilog/emt_strobe_seq.sv
`timescale 1ns/1ps
`default_nettype none
module emt_strobe_seq (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire emt_pkg::emt_timing_t cfg,
  input  wire logic                 req,
  input  wire logic                 req_write,
  input  wire logic                 req_expansion,
  output logic                      busy,
  output logic                      done,
  output logic                      oe_n,
  output logic                      we_n
);

  typedef struct packed {
    emt_pkg::emt_seq_state_t state;
    logic [3:0]              cnt;
    logic                    write;
    logic                    done;
    logic                    busy;
  } emt_seq_st_t;

  emt_seq_st_t st_ff;
  emt_seq_st_t nxt_st;
  logic        half_ff;
  logic        in_pulse;
  logic [3:0]  setup_len;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    setup_len = {1'b0, req_write ? cfg.wr_setup : cfg.rd_setup} +
                {3'h0, req_expansion & cfg.exp_setup};
    unique case (st_ff.state)
      emt_pkg::SQ_IDLE: begin
        if (req) begin
          nxt_st.write = req_write;
          if (setup_len == 4'h0) begin
            nxt_st.state = emt_pkg::SQ_PULSE;
            nxt_st.cnt   = {1'b0, req_write ? cfg.wr_pulse : cfg.rd_pulse};
          end else begin
            nxt_st.state = emt_pkg::SQ_SETUP;
            nxt_st.cnt   = setup_len - 4'h1;
          end
        end
      end
      emt_pkg::SQ_SETUP: begin
        if (st_ff.cnt == 4'h0) begin
          nxt_st.state = emt_pkg::SQ_PULSE;
          nxt_st.cnt   = {1'b0, st_ff.write ? cfg.wr_pulse : cfg.rd_pulse};
        end else begin
          nxt_st.cnt = st_ff.cnt - 4'h1;
        end
      end
      emt_pkg::SQ_PULSE: begin
        if (st_ff.cnt == 4'h0) begin
          if (st_ff.write && cfg.wr_hold != 3'h0) begin
            nxt_st.state = emt_pkg::SQ_HOLD;
            nxt_st.cnt   = {1'b0, cfg.wr_hold} - 4'h1;
          end else begin
            nxt_st.state = emt_pkg::SQ_IDLE;
            nxt_st.done  = 1'b1;
          end
        end else begin
          nxt_st.cnt = st_ff.cnt - 4'h1;
        end
      end
      emt_pkg::SQ_HOLD: begin
        if (st_ff.cnt == 4'h0) begin
          nxt_st.state = emt_pkg::SQ_IDLE;
          nxt_st.done  = 1'b1;
        end else begin
          nxt_st.cnt = st_ff.cnt - 4'h1;
        end
      end
    endcase
    // Busy is registered from the next state so the pin leaves a flop.
    nxt_st.busy = (nxt_st.state != emt_pkg::SQ_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{state: emt_pkg::SQ_IDLE, cnt: 4'h0, write: 1'b0, done: 1'b0, busy: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The pulse phase lasts one clock more than its field; the falling-edge
  // copy trims the leading half so the strobe opens mid-clock.
  assign in_pulse = (st_ff.state == emt_pkg::SQ_PULSE);

  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= in_pulse;
    end
  end

  // A pure flop cannot open on one edge and close on the other, so the
  // strobes are the AND of the two edge copies.
  assign oe_n = ~(half_ff & in_pulse & ~st_ff.write);
  assign we_n = ~(half_ff & in_pulse & st_ff.write);
  assign busy = st_ff.busy;
  assign done = st_ff.done;

endmodule
`default_nettype wire
